// *** test/pbpm_cfg_host.sv ***
// configuration-software model issuing single byte accesses
`timescale 1ns/100ps
`default_nettype none
module pbpm_cfg_host (
    input wire logic clk_in,
    input wire logic ack_in,
    input wire logic [7:0] rdata_in,
    output pbpm_pkg::pbpm_cfg_req_t cfg_out
);
    initial cfg_out = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // request stands for exactly one taking edge; the ack is then awaited, bounded
    // released address and data are inverted so stale values never look valid
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
            output logic [7:0] rdata, output logic ok);
        int n;
        @(negedge clk_in);
        cfg_out = {~wr, wr, addr, wdata};
        @(posedge clk_in);
        @(negedge clk_in);
        cfg_out = {2'b00, ~addr, ~wdata};
        ok = 1'b0;
        rdata = 8'h00;
        for (n = 0; n < 4 && ok == 1'b0; n++) begin
            if (ack_in === 1'b1) begin
                ok = 1'b1;
                rdata = rdata_in;
            end else begin
                @(negedge clk_in);
            end
        end
    endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking testbench for the power-management extension block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_in, reset_in, ce, d3cold, en_pin, sel_pin, ack, ok, usb_run;
    logic [7:0] rdata, rd;
    logic [127:0] data_table;
    logic [31:0] scale_table;
    pbpm_pkg::pbpm_cfg_req_t cfg;
    pbpm_pkg::pbpm_usb_t usb_state;
    pbpm_pkg::pbpm_sec_ctl_t sec_ctl;
    pbpm_pkg::pbpm_bstate_t bus_state;
    int num_errors = 0;
    int num_checks = 0;

    pbpm_top i_dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce), .cfg_in(cfg),
        .d3cold_in(d3cold), .bus_pm_en_pin_in(en_pin), .d3_sel_pin_in(sel_pin),
        .data_table_in(data_table), .scale_table_in(scale_table), .usb_state_in(usb_state),
        .cfg_rdata_out(rdata), .cfg_ack_out(ack), .sec_ctl_out(sec_ctl),
        .bus_state_out(bus_state), .usb_run_out(usb_run));
    pbpm_cfg_host i_host (.clk_in(clk_in), .ack_in(ack), .rdata_in(rdata), .cfg_out(cfg));

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t register read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t output %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_byte(input logic [7:0] addr, input logic [7:0] exp);
        i_host.access(1'b0, addr, 8'h00, rd, ok);
        chk_byte(ok ? rd : 8'hxx, exp);
    endtask

    task automatic wr_byte(input logic [7:0] addr, input logic [7:0] data);
        i_host.access(1'b1, addr, data, rd, ok);
        chk_byte({7'h00, ok}, 8'h01);
    endtask

    function automatic pbpm_pkg::pbpm_bstate_t exp_bus(input int pst, input logic sel);
        case (pst)
            0: return pbpm_pkg::PBPM_B0;
            1: return pbpm_pkg::PBPM_B1;
            2: return pbpm_pkg::PBPM_B2;
            default: return sel ? pbpm_pkg::PBPM_B2 : pbpm_pkg::PBPM_B3;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        int pst;
        int s;
        reset_in = 1'b1;
        ce = 1'b1;
        d3cold = 1'b0;
        en_pin = 1'b0;
        sel_pin = 1'b0;
        usb_state = pbpm_pkg::PBPM_USB_RESET;
        // data table entries differ per select so a wrong index shows up; scale entries repeat every four selects
        for (i = 0; i < 16; i++) begin
            data_table[i*8+:8] = {4'ha, i[3:0]};
            scale_table[i*2+:2] = i[1:0];
        end
        repeat (12) @(negedge clk_in);
        reset_in = 1'b0;
        repeat (8) @(negedge clk_in);
        rd_byte(8'h3a, 8'h00);
        rd_byte(8'h3b, 8'ha0);
        rd_byte(8'h40, 8'h00);
        wr_byte(8'h3a, 8'hff);
        wr_byte(8'h3b, 8'h5a);
        rd_byte(8'h3a, 8'h00);
        rd_byte(8'h3b, 8'ha0);
        for (i = 0; i < 16; i += 5) begin
            wr_byte(8'h39, {3'b000, i[3:0], 1'b0});
            rd_byte(8'h3b, {4'ha, i[3:0]});
            rd_byte(8'h39, {1'b0, i[1:0], i[3:0], 1'b0});
        end
        // select high but enable low: no bus action in any state
        sel_pin = 1'b1;
        repeat (8) @(negedge clk_in);
        rd_byte(8'h3a, 8'h40);
        for (pst = 0; pst < 4; pst++) begin
            wr_byte(8'h38, {6'h00, pst[1:0]});
            rd_byte(8'h38, {6'h00, pst[1:0]});
            repeat (3) @(negedge clk_in);
            chk_pin({5'h00, sec_ctl}, 8'h00);
        end
        en_pin = 1'b1;
        for (s = 1; s >= 0; s--) begin
            sel_pin = s[0];
            repeat (8) @(negedge clk_in);
            rd_byte(8'h3a, {1'b1, s[0], 6'h00});
            for (pst = 0; pst < 4; pst++) begin
                wr_byte(8'h38, {6'h00, pst[1:0]});
                repeat (3) @(negedge clk_in);
                chk_pin({6'h00, sec_ctl.clk_stop, sec_ctl.pwr_off},
                    {6'h00, pst >= 2, pst == 3 && s == 0});
                chk_pin({6'h00, bus_state}, {6'h00, exp_bus(pst, s[0])});
                // packed order is clk_stop, pwr_off, idle
                case (exp_bus(pst, s[0]))
                    pbpm_pkg::PBPM_B0: chk_pin({5'h00, sec_ctl}, 8'h00);
                    pbpm_pkg::PBPM_B2: chk_pin({5'h00, sec_ctl}, 8'h04);
                    pbpm_pkg::PBPM_B3: chk_pin({5'h00, sec_ctl}, 8'h06);
                    default: chk_pin({5'h00, sec_ctl}, 8'h01);
                endcase
            end
        end
        d3cold = 1'b1;
        repeat (3) @(negedge clk_in);
        chk_pin({6'h00, bus_state}, {6'h00, pbpm_pkg::PBPM_B3});
        chk_pin({6'h00, sec_ctl.clk_stop, sec_ctl.pwr_off}, 8'h00);
        d3cold = 1'b0;
        // bit 0 of the state code marks the running states
        for (i = 0; i < 4; i++) begin
            usb_state = pbpm_pkg::pbpm_usb_t'(i[1:0]);
            repeat (3) @(negedge clk_in);
            chk_pin({7'h00, usb_run}, {7'h00, i[0]});
        end
        // clock enable low must freeze the run flag despite a new usb state
        ce = 1'b0;
        usb_state = pbpm_pkg::PBPM_USB_SUSPEND;
        repeat (3) @(negedge clk_in);
        chk_pin({7'h00, usb_run}, 8'h01);
        ce = 1'b1;
        repeat (3) @(negedge clk_in);
        chk_pin({7'h00, usb_run}, 8'h00);
        tally_and_finish();
    end

    // the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        $display("BAD %0t run did not complete in time", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** verilog/pbpm_pkg.sv ***
// package: constants and carriers for the bridge power-management extension block
package pbpm_pkg;
    // config byte offsets within the capability (base + n)
    localparam logic [7:0] PBPM_CAP_BASE = 8'h34;
    localparam logic [7:0] PBPM_OFS_PWR_CTL = 8'h04;
    localparam logic [7:0] PBPM_OFS_EXT = 8'h06;
    localparam logic [7:0] PBPM_OFS_DATA = 8'h07;
    // field positions
    localparam int PBPM_BIT_BUS_PM_EN = 7;
    localparam int PBPM_BIT_D3_SEL = 6;
    localparam int PBPM_PWR_STATE_LSB = 0;
    localparam int PBPM_DSEL_LSB = 9;
    localparam int PBPM_DSCALE_LSB = 13;
    // reset values
    localparam logic [7:0] PBPM_EXT_RST = 8'h00;
    localparam logic [7:0] PBPM_DATA_RST = 8'h00;
    localparam logic [1:0] PBPM_PWR_STATE_RST = 2'h0;
    localparam logic [3:0] PBPM_DSEL_RST = 4'h0;
    localparam int PBPM_SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        PBPM_D0 = 2'b00,
        PBPM_D1 = 2'b01,
        PBPM_D2 = 2'b10,
        PBPM_D3HOT = 2'b11
    } pbpm_dstate_t;

    // secondary bus state, gray along B0-B1-B2-B3
    typedef enum logic [1:0] {
        PBPM_B0 = 2'b00,
        PBPM_B1 = 2'b01,
        PBPM_B2 = 2'b11,
        PBPM_B3 = 2'b10
    } pbpm_bstate_t;

    typedef enum logic [1:0] {
        PBPM_USB_RESET = 2'b00,
        PBPM_USB_OPER = 2'b01,
        PBPM_USB_RESUME = 2'b11,
        PBPM_USB_SUSPEND = 2'b10
    } pbpm_usb_t;

    // configuration byte access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pbpm_cfg_req_t;

    // secondary bus controls
    typedef struct packed {
        logic clk_stop;
        logic pwr_off;
        logic idle;
    } pbpm_sec_ctl_t;
endpackage

// *** verilog/pbpm_sync.sv ***
// three-stage synchroniser for pin straps
`timescale 1ns/100ps
`default_nettype none
module pbpm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_out <= '0;
        end else if (ce_in) begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // a change counts only once two settled stages agree
            if (s2_r == s3_r) begin
                q_out <= s3_r;
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/pbpm_top.sv ***
// power-management extension byte, data byte and secondary bus control
`timescale 1ns/100ps
`default_nettype none
module pbpm_top #(
    parameter int NUM_SEL = 16
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire pbpm_pkg::pbpm_cfg_req_t cfg_in,
    input wire logic d3cold_in,
    input wire logic bus_pm_en_pin_in,
    input wire logic d3_sel_pin_in,
    input wire logic [NUM_SEL*8-1:0] data_table_in,
    input wire logic [NUM_SEL*2-1:0] scale_table_in,
    input wire pbpm_pkg::pbpm_usb_t usb_state_in,
    output logic [7:0] cfg_rdata_out,
    output logic cfg_ack_out,
    output pbpm_pkg::pbpm_sec_ctl_t sec_ctl_out,
    output pbpm_pkg::pbpm_bstate_t bus_state_out,
    output logic usb_run_out
);
    logic [1:0] strap_q;
    logic [7:0] ext_r;
    logic [7:0] data_r;
    logic [1:0] scale_r;
    logic [1:0] pwr_state_r;
    logic [3:0] dsel_r;
    logic d3cold_r;
    logic [7:0] rd_nxt;
    pbpm_pkg::pbpm_bstate_t bstate_nxt;

    ////////////////////////////////////////////////////////////////////////
    // enable and select straps arrive from pins
    pbpm_sync #(.WIDTH(2)) u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .d_in({bus_pm_en_pin_in, d3_sel_pin_in}),
        .q_out(strap_q)
    );

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ext_r <= pbpm_pkg::PBPM_EXT_RST;
        end else if (ce_in) begin
            ext_r <= {strap_q, 6'h00};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power state written and read back
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pwr_state_r <= pbpm_pkg::PBPM_PWR_STATE_RST;
        end else if (ce_in && cfg_in.wr &&
                     cfg_in.addr == pbpm_pkg::PBPM_CAP_BASE + pbpm_pkg::PBPM_OFS_PWR_CTL) begin
            pwr_state_r <= cfg_in.wdata[1:0];
        end
    end

    // data select in high byte of the control word
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            dsel_r <= pbpm_pkg::PBPM_DSEL_RST;
        end else if (ce_in && cfg_in.wr && cfg_in.addr ==
                     pbpm_pkg::PBPM_CAP_BASE + pbpm_pkg::PBPM_OFS_PWR_CTL + 8'h01) begin
            dsel_r <= cfg_in.wdata[4:1];
        end
    end

    // data and scale follow the selected entry
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            data_r <= pbpm_pkg::PBPM_DATA_RST;
            scale_r <= 2'h0;
        end else if (ce_in) begin
            data_r <= data_table_in[dsel_r*8 +: 8];
            scale_r <= scale_table_in[dsel_r*2 +: 2];
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            d3cold_r <= 1'b0;
        end else if (ce_in) begin
            d3cold_r <= d3cold_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; writes to read-only bytes fall through untouched
    always_comb begin
        rd_nxt = 8'h00;
        if (cfg_in.addr == pbpm_pkg::PBPM_CAP_BASE + pbpm_pkg::PBPM_OFS_PWR_CTL) begin
            rd_nxt = {6'h00, pwr_state_r};
        end else if (cfg_in.addr ==
                     pbpm_pkg::PBPM_CAP_BASE + pbpm_pkg::PBPM_OFS_PWR_CTL + 8'h01) begin
            rd_nxt = {1'b0, scale_r, dsel_r, 1'b0};
        end else if (cfg_in.addr == pbpm_pkg::PBPM_CAP_BASE + pbpm_pkg::PBPM_OFS_EXT) begin
            rd_nxt = ext_r;
        end else if (cfg_in.addr == pbpm_pkg::PBPM_CAP_BASE + pbpm_pkg::PBPM_OFS_DATA) begin
            rd_nxt = data_r;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cfg_rdata_out <= 8'h00;
            cfg_ack_out <= 1'b0;
        end else if (ce_in) begin
            cfg_ack_out <= cfg_in.rd | cfg_in.wr;
            cfg_rdata_out <= cfg_in.rd ? rd_nxt : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // secondary bus state from function state
    always_comb begin
        case (pbpm_dstate_e(pwr_state_r))
            pbpm_pkg::PBPM_D0: bstate_nxt = pbpm_pkg::PBPM_B0;
            pbpm_pkg::PBPM_D1: bstate_nxt = pbpm_pkg::PBPM_B1;
            pbpm_pkg::PBPM_D2: bstate_nxt = pbpm_pkg::PBPM_B2;
            // select only honoured with enable set
            pbpm_pkg::PBPM_D3HOT: bstate_nxt = (ext_r[pbpm_pkg::PBPM_BIT_BUS_PM_EN] &&
                                  !ext_r[pbpm_pkg::PBPM_BIT_D3_SEL]) ?
                                  pbpm_pkg::PBPM_B3 : pbpm_pkg::PBPM_B2;
            default: bstate_nxt = pbpm_pkg::PBPM_B0;
        endcase
        // D3cold: power already gone, bridge does nothing
        if (d3cold_r) begin
            bstate_nxt = pbpm_pkg::PBPM_B3;
        end
    end

    // drive the secondary bus only when enabled
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bus_state_out <= pbpm_pkg::PBPM_B0;
            sec_ctl_out <= '0;
        end else if (ce_in) begin
            bus_state_out <= bstate_nxt;
            if (!ext_r[pbpm_pkg::PBPM_BIT_BUS_PM_EN] || d3cold_r) begin
                sec_ctl_out <= '0;
            end else begin
                sec_ctl_out.idle <= (bstate_nxt == pbpm_pkg::PBPM_B1);
                sec_ctl_out.clk_stop <= (bstate_nxt == pbpm_pkg::PBPM_B2) ||
                                        (bstate_nxt == pbpm_pkg::PBPM_B3);
                sec_ctl_out.pwr_off <= (bstate_nxt == pbpm_pkg::PBPM_B3);
            end
        end
    end

    // usb system runs in operational and resume only
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            usb_run_out <= 1'b0;
        end else if (ce_in) begin
            usb_run_out <= (usb_state_in == pbpm_pkg::PBPM_USB_OPER) ||
                           (usb_state_in == pbpm_pkg::PBPM_USB_RESUME);
        end
    end

    function automatic pbpm_pkg::pbpm_dstate_t pbpm_dstate_e(input logic [1:0] v);
        pbpm_dstate_e = pbpm_pkg::pbpm_dstate_t'(v);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence s_d2_written;
        ce_in && pwr_state_r == pbpm_pkg::PBPM_D2 && ext_r[7] && !d3cold_r;
    endsequence

    a_disabled_no_action: assert property (
        ce_in && !ext_r[7] |=> sec_ctl_out == '0)
        else $error("secondary bus touched while disabled");
    a_d3_clock_stop: assert property (
        ce_in && pwr_state_r == 2'b11 && ext_r[7] && ext_r[6] && !d3cold_r
        |=> sec_ctl_out.clk_stop && !sec_ctl_out.pwr_off)
        else $error("d3hot with select high must only stop clock");
    a_d3_power_off: assert property (
        ce_in && pwr_state_r == 2'b11 && ext_r[7] && !ext_r[6] && !d3cold_r
        |=> sec_ctl_out.pwr_off && sec_ctl_out.clk_stop)
        else $error("d3hot with select low must remove power");
    a_d0_no_action: assert property (
        ce_in && pwr_state_r == 2'b00 |=> !sec_ctl_out.clk_stop && !sec_ctl_out.pwr_off)
        else $error("action taken in D0");
    a_d2_clock_stop: assert property (
        s_d2_written |=> sec_ctl_out.clk_stop && !sec_ctl_out.pwr_off)
        else $error("D2 must stop clock only");
    a_ro_ext_stable: assert property (
        ce_in ##1 ce_in && $stable(strap_q) |=> $stable(ext_r))
        else $error("extension byte changed without strap change");
    a_data_read: assert property (
        ce_in && cfg_in.rd && cfg_in.addr == 8'h3b |=> cfg_ack_out && cfg_rdata_out == $past(data_r))
        else $error("data byte read wrong");
    a_usb_halt: assert property (
        ce_in && (usb_state_in == pbpm_pkg::PBPM_USB_RESET ||
        usb_state_in == pbpm_pkg::PBPM_USB_SUSPEND) |=> !usb_run_out)
        else $error("usb running in reset or suspend");
    a_usb_run: assert property (
        ce_in && usb_state_in == pbpm_pkg::PBPM_USB_OPER |=> usb_run_out)
        else $error("usb halted while operational");
endmodule
`default_nettype wire
